// ===== core/i2c_port_cfg.svh
// Constants for the two-address serial slave port
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// Fixed slave address of the auxiliary memory
`define AUX_SLAVE_ADDR 8'ha0

// Main-table register offsets and their reset values
`define MAIN_ADDR_OFFSET 8'h8c
`define MAIN_ADDR_RESET 8'ha2
`define CONFIG_OFFSET 8'h89
`define CONFIG_RESET 8'h00

// Bit of the config byte that enables the programmable main address
`define MAIN_ADDRESS_SELECT_ENABLE_BIT 0

// Address counter bits that step inside one 8-byte row
`define ROW_BITS 3

// Bit count of a byte on the wire, acknowledge bit not counted
`define BYTE_BITS 4'h8

// Nonvolatile page write time and the system clock period
`define WRITE_TIME_NS 10000000
`define SYS_CLK_PERIOD_NS 20
`define WRITE_BUSY_CYCLES ((`WRITE_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// ===== core/i2c_port_pkg.sv
// Types shared by the two-address serial slave port
package i2c_port_pkg;

    // Bus phase of the slave engine
    typedef enum logic [2:0] {
        phase_idle,
        phase_rx,
        phase_ack,
        phase_tx,
        phase_mack
    } phase_t;

    // Meaning of the byte being received
    typedef enum logic [1:0] {
        kind_slave,
        kind_mem,
        kind_data
    } kind_t;

    // Whole state of the slave engine
    typedef struct packed {
        phase_t phase;
        kind_t kind;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] addr;
        logic sel_main;
        logic read_dir;
        logic page_dirty;
        logic master_nack;
        logic scl_d;
        logic sda_d;
        logic sda_oe;
        logic [7:0] main_addr;
        logic [7:0] config_byte;
        logic [31:0] busy_cnt;
        logic busy;
    } state_t;

    // Write strobe into one of the two memories
    typedef struct packed {
        logic en;
        logic sel_main;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_t;

endpackage

// ===== core/pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta <= RESET_VALUE;
            q_o <= RESET_VALUE;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== core/i2c_slave_port.sv
// Two-wire slave port with fixed auxiliary and programmable main address
//
// Functional notes
// - START: SDA falls while SCL high
// - STOP: SDA rises while SCL high, ends
// - Repeated START restarts like a START
// - Idle bus leaves SDA and SCL released
// - Incoming bits sampled on SCL rising edge
// - Outgoing bit driven after SCL falling edge
// - Ninth bit: zero acknowledges, one refuses
// - Write byte MSB first, device acknowledges
// - Read byte MSB first, master NACK ends
// - First byte: 7-bit address plus direction
// - Direction zero writes, one reads
// - Fixed auxiliary address reaches 256-byte space
// - Programmable main address reaches main tables
// - Main address needs select enable bit
// - Unmatched address: silent until next START
// - Main address equal auxiliary disables auxiliary
// - Second write byte loads address counter
// - Write counter wraps inside 8-byte row
// - Read starts at current address counter
// - No address acknowledge during page write
`timescale 1ns/100ps
`default_nettype none
`include "i2c_port_cfg.svh"

module i2c_slave_port #(
    parameter int WRITE_BUSY_CYCLES = `WRITE_BUSY_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic busy_o
);

    // The busy counter is 32 bits wide and must count at least once
    if (WRITE_BUSY_CYCLES < 1 || WRITE_BUSY_CYCLES > 32'h7fff_ffff)
    begin : g_busy_check
        $error("WRITE_BUSY_CYCLES out of range");
    end

    localparam logic [31:0] BUSY_LOAD = 32'(WRITE_BUSY_CYCLES);
    localparam logic [6:0] AUX7 = 7'(`AUX_SLAVE_ADDR >> 1);
    localparam logic [6:0] MAIN7 = 7'(`MAIN_ADDR_RESET >> 1);

    localparam i2c_port_pkg::state_t STATE_RESET = '{
        phase: i2c_port_pkg::phase_idle,
        kind: i2c_port_pkg::kind_slave,
        bit_cnt: 4'h0,
        shift: 8'h00,
        tx: 8'h00,
        addr: 8'h00,
        sel_main: 1'b0,
        read_dir: 1'b0,
        page_dirty: 1'b0,
        master_nack: 1'b0,
        scl_d: 1'b1,
        sda_d: 1'b1,
        sda_oe: 1'b0,
        main_addr: `MAIN_ADDR_RESET,
        config_byte: `CONFIG_RESET,
        busy_cnt: 32'h0000_0000,
        busy: 1'b0
    };

    i2c_port_pkg::state_t st;
    i2c_port_pkg::state_t next_st;
    i2c_port_pkg::mem_wr_t next_wr;

    logic [7:0] aux_mem [0:255];
    logic [7:0] main_mem [0:255];

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic main_hit;
    logic [7:0] main_eff;
    logic aux_hit;
    logic [7:0] rd_byte;
    logic load_tx;

    // Both pins arrive from the master's clock; idle level is high
    pin_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'h3)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i({scl_i, sda_i}),
        .q_o({scl_s, sda_s})
    );

    // Edges of the master's clock; this end never makes SCL itself
    assign scl_rise = scl_s & ~st.scl_d;
    assign scl_fall = ~scl_s & st.scl_d;
    // Bus conditions: SDA moving while SCL stays high
    assign start_det = scl_s & st.scl_d & st.sda_d & ~sda_s;
    assign stop_det = scl_s & st.scl_d & ~st.sda_d & sda_s;

    // Address decode on the received slave byte
    always_comb
    begin
        // Until enabled the tables sit at the reset address, else the enable is unreachable
        main_eff = st.config_byte[`MAIN_ADDRESS_SELECT_ENABLE_BIT] ? st.main_addr : `MAIN_ADDR_RESET;
        main_hit = (st.shift[7:1] == main_eff[7:1]);
        // A main address of A0h shadows the auxiliary memory entirely
        aux_hit = (st.shift[7:1] == AUX7)
            && (main_eff != `AUX_SLAVE_ADDR);
    end

    // Read data; the two main registers live in flops, not the array
    always_comb
    begin
        if (!st.sel_main)
        begin
            rd_byte = aux_mem[st.addr];
        end
        else if (st.addr == `MAIN_ADDR_OFFSET)
        begin
            rd_byte = st.main_addr;
        end
        else if (st.addr == `CONFIG_OFFSET)
        begin
            rd_byte = st.config_byte;
        end
        else
        begin
            rd_byte = main_mem[st.addr];
        end
    end

    // Slave engine
    always_comb
    begin
        next_st = st;
        next_wr = '0;
        load_tx = 1'b0;
        next_st.scl_d = scl_s;
        next_st.sda_d = sda_s;
        if (st.busy_cnt != 32'h0000_0000)
        begin
            next_st.busy_cnt = st.busy_cnt - 32'h0000_0001;
        end
        if (start_det)
        begin
            // A START anywhere, repeated or not, begins a fresh address byte
            next_st.phase = i2c_port_pkg::phase_rx;
            next_st.kind = i2c_port_pkg::kind_slave;
            next_st.bit_cnt = 4'h0;
            next_st.sda_oe = 1'b0;
        end
        else if (stop_det)
        begin
            next_st.phase = i2c_port_pkg::phase_idle;
            next_st.sda_oe = 1'b0;
            // Page commit keeps the slave deaf to its address for a while
            if (st.page_dirty)
            begin
                next_st.busy_cnt = BUSY_LOAD;
                next_st.page_dirty = 1'b0;
            end
        end
        else
        begin
            case (st.phase)
                i2c_port_pkg::phase_rx:
                begin
                    if (scl_rise)
                    begin
                        next_st.shift = {st.shift[6:0], sda_s};
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && st.bit_cnt == `BYTE_BITS)
                    begin
                        next_st.bit_cnt = 4'h0;
                        if (st.kind == i2c_port_pkg::kind_slave)
                        begin
                            if ((main_hit || aux_hit) && st.busy_cnt == 32'h0000_0000)
                            begin
                                next_st.sda_oe = 1'b1;
                                next_st.phase = i2c_port_pkg::phase_ack;
                                next_st.sel_main = main_hit;
                                next_st.read_dir = st.shift[0];
                            end
                            else
                            begin
                                // Not ours, or ours while a page write keeps it busy: stay off the bus until a START
                                next_st.phase = i2c_port_pkg::phase_idle;
                            end
                        end
                        else if (st.kind == i2c_port_pkg::kind_mem)
                        begin
                            next_st.addr = st.shift;
                            next_st.sda_oe = 1'b1;
                            next_st.phase = i2c_port_pkg::phase_ack;
                        end
                        else
                        begin
                            next_wr.en = 1'b1;
                            next_wr.sel_main = st.sel_main;
                            next_wr.addr = st.addr;
                            next_wr.data = st.shift;
                            if (st.sel_main && st.addr == `MAIN_ADDR_OFFSET)
                            begin
                                next_st.main_addr = st.shift;
                            end
                            if (st.sel_main && st.addr == `CONFIG_OFFSET)
                            begin
                                next_st.config_byte = st.shift;
                            end
                            // Step within the row; the row bits never change
                            next_st.addr[`ROW_BITS-1:0] =
                                st.addr[`ROW_BITS-1:0] + `ROW_BITS'(1);
                            next_st.page_dirty = 1'b1;
                            next_st.sda_oe = 1'b1;
                            next_st.phase = i2c_port_pkg::phase_ack;
                        end
                    end
                end
                i2c_port_pkg::phase_ack:
                begin
                    if (scl_fall)
                    begin
                        next_st.sda_oe = 1'b0;
                        next_st.bit_cnt = 4'h0;
                        if (st.read_dir)
                        begin
                            load_tx = 1'b1;
                        end
                        else
                        begin
                            next_st.phase = i2c_port_pkg::phase_rx;
                            if (st.kind == i2c_port_pkg::kind_slave)
                            begin
                                next_st.kind = i2c_port_pkg::kind_mem;
                            end
                            else
                            begin
                                next_st.kind = i2c_port_pkg::kind_data;
                            end
                        end
                    end
                end
                i2c_port_pkg::phase_tx:
                begin
                    if (scl_fall)
                    begin
                        if (st.bit_cnt == `BYTE_BITS)
                        begin
                            // Release for the master's acknowledge bit
                            next_st.sda_oe = 1'b0;
                            next_st.phase = i2c_port_pkg::phase_mack;
                        end
                        else
                        begin
                            next_st.tx = {st.tx[6:0], 1'b0};
                            next_st.sda_oe = ~st.tx[6];
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                        end
                    end
                end
                i2c_port_pkg::phase_mack:
                begin
                    if (scl_rise)
                    begin
                        next_st.master_nack = sda_s;
                    end
                    else if (scl_fall)
                    begin
                        if (st.master_nack)
                        begin
                            next_st.phase = i2c_port_pkg::phase_idle;
                        end
                        else
                        begin
                            load_tx = 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end
        // First bit of a read byte goes out on the same falling edge
        if (load_tx)
        begin
            next_st.tx = rd_byte;
            next_st.sda_oe = ~rd_byte[7];
            next_st.bit_cnt = 4'h1;
            next_st.addr = st.addr + 8'h01;
            next_st.phase = i2c_port_pkg::phase_tx;
        end
        next_st.busy = next_st.busy_cnt != 32'h0000_0000;
    end

    // State register
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st <= STATE_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Memory arrays hold no reset; power-up content is undefined
    always_ff @(posedge sys_clk_i)
    begin
        if (next_wr.en && next_wr.sel_main)
        begin
            main_mem[next_wr.addr] <= next_wr.data;
        end
        if (next_wr.en && !next_wr.sel_main)
        begin
            aux_mem[next_wr.addr] <= next_wr.data;
        end
    end

    // Open drain: the data output is always low, only the enable moves
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sda_o <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o = st.sda_oe;
    assign busy_o = st.busy;

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    start_to_addr_a: assert property (
        start_det |=> st.phase == i2c_port_pkg::phase_rx && st.kind == i2c_port_pkg::kind_slave
            && st.bit_cnt == 4'h0 && !sda_oe_o)
        else $error("START did not restart address byte");

    stop_to_idle_a: assert property (
        stop_det |=> st.phase == i2c_port_pkg::phase_idle && !sda_oe_o)
        else $error("STOP did not end transfer");

    idle_released_a: assert property (
        st.phase == i2c_port_pkg::phase_idle |-> !sda_oe_o)
        else $error("SDA driven while idle");

    rise_sample_a: assert property (
        st.phase == i2c_port_pkg::phase_rx && scl_rise && !start_det && !stop_det
            |=> st.shift[0] == $past(sda_s) && st.bit_cnt == $past(st.bit_cnt) + 4'h1)
        else $error("Bit not sampled on SCL rise");

    drive_after_fall_a: assert property (
        $changed(sda_oe_o) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("SDA changed away from SCL fall");

    ack_drives_low_a: assert property (
        st.phase == i2c_port_pkg::phase_ack |-> sda_oe_o && !sda_o)
        else $error("Acknowledge not driven low");

    unmatched_silent_a: assert property (
        st.phase == i2c_port_pkg::phase_rx && st.kind == i2c_port_pkg::kind_slave
            && scl_fall && st.bit_cnt == `BYTE_BITS && !main_hit && !aux_hit
            && !start_det && !stop_det
            |=> st.phase == i2c_port_pkg::phase_idle && !sda_oe_o)
        else $error("Unmatched address was answered");

    busy_refuses_a: assert property (
        busy_o && st.phase == i2c_port_pkg::phase_rx && st.kind == i2c_port_pkg::kind_slave
            && scl_fall && st.bit_cnt == `BYTE_BITS && !start_det && !stop_det
            |=> !sda_oe_o ##1 !sda_oe_o)
        else $error("Address acknowledged during page write");

    aux_shadowed_a: assert property (
        main_eff == `AUX_SLAVE_ADDR |-> !aux_hit)
        else $error("Auxiliary memory answered while shadowed");

    row_wrap_a: assert property (
        next_wr.en |=> st.addr[7:`ROW_BITS] == $past(st.addr[7:`ROW_BITS])
            || $past(start_det) || $past(stop_det))
        else $error("Write counter left its row");

    main_enable_a: assert property (
        !st.config_byte[`MAIN_ADDRESS_SELECT_ENABLE_BIT] && st.shift[7:1] != MAIN7 |-> !main_hit)
        else $error("Main address active without enable");

endmodule

`default_nettype wire

// ===== bench/i2c_master_model.sv
// Behavioural two-wire bus master that drives the slave port's pins
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // A quarter of the 160 ns link clock period
    localparam int QTR = 40;

    // Idle bus: clock high and data released; the clock stands still between frames
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull_o = 1'b0;
        #QTR scl_o = 1'b1;
        #(2*QTR) sda_pull_o = 1'b1;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    // Stop: data rises while the clock is high, then the bus is left idle
    task automatic stop();
        sda_pull_o = 1'b1;
        #QTR scl_o = 1'b1;
        #(2*QTR) sda_pull_o = 1'b0;
        #(2*QTR);
    endtask

    // One bit; sampled late in the high phase because the slave answers
    // several system clocks after each clock edge
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = ~b;
        #QTR scl_o = 1'b1;
        #(QTR+20) r = sda_i;
        #20 scl_o = 1'b0;
        #QTR;
    endtask

    // Eight bits most significant first, then the ninth bit
    task automatic byte_io(input logic [7:0] d, input logic nin, output logic [7:0] q,
        output logic ninth);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(nin, ninth);
    endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the two-address serial slave port
`timescale 1ns/100ps
`default_nettype none
`include "i2c_port_cfg.svh"

module testbench;
    // Short page write time keeps the run brief but longer than one polling byte
    localparam int BUSY = 400;
    localparam int LIMIT = 10000;

    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic scl;
    logic sda_pull;
    logic sda;
    logic sda_o;
    logic sda_oe_o;
    logic busy_o;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    // Resolved open-drain wire with a pull-up
    assign sda = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;

    i2c_slave_port #(.WRITE_BUSY_CYCLES(BUSY)) dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));

    i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // The slave may only ever pull the line low
    always @(posedge sys_clk_i)
    begin
        if (!reset_i && sda_o !== 1'b0)
            check({7'h00, sda_o}, 8'h00, "sda data not low");
    end

    // Hang guard
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            $display("[FAIL] t=%0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic send(input logic [7:0] d, output logic ack);
        logic [7:0] q;
        m.byte_io(d, 1'b1, q, ack);
    endtask

    task automatic recv(input logic nack, output logic [7:0] q);
        logic a;
        m.byte_io(8'hff, nack, q, a);
    endtask

    // Transactions begin a fixed delay after a clock edge
    task automatic align();
        @(posedge sys_clk_i);
        #2;
    endtask

    // Address byte only, then STOP; expected ninth bit given
    task automatic probe(input logic [7:0] sa, input logic exp_nack);
        logic a;
        align();
        m.start();
        send(sa, a);
        check({7'h00, a}, {7'h00, exp_nack}, "address answer");
        m.stop();
        repeat (4) @(posedge sys_clk_i);
    endtask

    // One data byte, then wait out the page write
    task automatic write_one(input logic [7:0] sa, input logic [7:0] loc, input logic [7:0] d);
        logic a;
        align();
        m.start();
        send(sa, a);
        check({7'h00, a}, 8'h00, "write address ack");
        send(loc, a);
        check({7'h00, a}, 8'h00, "write location ack");
        send(d, a);
        check({7'h00, a}, 8'h00, "write data ack");
        m.stop();
        repeat (4) @(posedge sys_clk_i);
        for (int n = 0; n < 1000 && busy_o !== 1'b0; n++)
            @(posedge sys_clk_i);
    endtask

    task automatic test_reset_and_main();
        check({6'h00, sda_oe_o, busy_o}, 8'h00, "reset outputs");
        probe(`MAIN_ADDR_RESET, 1'b0);
        write_one(`MAIN_ADDR_RESET, `MAIN_ADDR_OFFSET, 8'h60);
        probe(8'h60, 1'b1);
        write_one(`MAIN_ADDR_RESET, `CONFIG_OFFSET, 8'h01);
        probe(8'h60, 1'b0);
        probe(`MAIN_ADDR_RESET, 1'b1);
        write_one(8'h60, `MAIN_ADDR_OFFSET, `AUX_SLAVE_ADDR);
        read_at(`MAIN_ADDR_OFFSET, 1, '{`AUX_SLAVE_ADDR, 8'h00});
        write_one(`AUX_SLAVE_ADDR, `MAIN_ADDR_OFFSET, 8'h60);
        $display("test reset_and_main done");
    endtask

    task automatic test_unmatched();
        logic a;
        align();
        m.start();
        send(8'h50, a);
        check({7'h00, a}, 8'h01, "foreign address acknowledged");
        send(8'h00, a);
        check({7'h00, a}, 8'h01, "byte after foreign address acknowledged");
        m.stop();
        $display("test unmatched done");
    endtask

    task automatic test_aux_write();
        logic a;
        logic [7:0] data [3] = '{8'h11, 8'h22, 8'h33};
        align();
        m.start();
        send(`AUX_SLAVE_ADDR, a);
        check({7'h00, a}, 8'h00, "aux address ack");
        send(8'h06, a);
        check({7'h00, a}, 8'h00, "memory address ack");
        for (int i = 0; i < 3; i++)
        begin
            send(data[i], a);
            check({7'h00, a}, 8'h00, "data ack");
        end
        m.stop();
        repeat (4) @(posedge sys_clk_i);
        check({7'h00, busy_o}, 8'h01, "busy after stop");
        align();
        m.start();
        send(`AUX_SLAVE_ADDR, a);
        check({7'h00, a}, 8'h01, "address ack while busy");
        m.stop();
        for (int n = 0; n < 1000 && busy_o !== 1'b0; n++)
            @(posedge sys_clk_i);
        check({7'h00, busy_o}, 8'h00, "busy never ended");
        $display("test aux_write done");
    endtask

    // Dummy write sets the counter, repeated start turns the bus round
    task automatic read_at(input logic [7:0] loc, input int n, input logic [7:0] exp [2]);
        logic a;
        logic [7:0] q;
        align();
        m.start();
        send(`AUX_SLAVE_ADDR, a);
        check({7'h00, a}, 8'h00, "aux ack after busy");
        send(loc, a);
        check({7'h00, a}, 8'h00, "dummy memory address ack");
        m.start();
        send(`AUX_SLAVE_ADDR | 8'h01, a);
        check({7'h00, a}, 8'h00, "read address ack");
        for (int i = 0; i < n; i++)
        begin
            recv(i == n - 1, q);
            check(q, exp[i], "read data");
        end
        m.stop();
        repeat (4) @(posedge sys_clk_i);
        check({7'h00, sda_oe_o}, 8'h00, "line held after nack");
    endtask

    task automatic test_aux_read();
        read_at(8'h06, 2, '{8'h11, 8'h22});
        read_at(8'h00, 1, '{8'h33, 8'h00});
        $display("test aux_read done");
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        #2 reset_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        test_reset_and_main();
        test_unmatched();
        test_aux_write();
        test_aux_read();
        report_and_stop();
    end
endmodule
`default_nettype wire
